//--- clocked_serial_interface.sv
// Our own choice: the Wishbone register port.
`timescale 1ns/1ps
`default_nettype none

module clocked_serial_interface (
   input wire logic clk_i,
   input wire logic rst_i,
   // Wishbone classic slave
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [csi_pkg::ADR_W-1:0] adr_i,
   input wire logic [3:0] sel_i,
   input wire logic [csi_pkg::DAT_W-1:0] dat_i,
   output logic [csi_pkg::DAT_W-1:0] dat_o,
   output logic ack_o,
   // Rate enables from the clock system, same domain
   input wire logic osc_edge_i,
   input wire logic timer1_underflow_i,
   // Serial pins
   input wire logic serial_in_pin_i,
   input wire logic sclk_pin_i,
   output logic sclk_pin_o,
   output logic sclk_pin_oe_n_o,
   output logic serial_out_pin_o,
   output logic serial_out_pin_oe_n_o,
   output logic slave_ready_pin_n_o,
   output logic slave_ready_pin_oe_n_o,
   output logic serial_pin_function_o,
   output logic input_pin_pullup_o,
   output logic clock_pin_pullup_o,
   output logic irq_o
);

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   // Registers sit on word boundaries; a byte offset inside a word misses,
   // so one nibble can never alias onto two registers
   function automatic logic hit(input logic [csi_pkg::ADR_W-1:0] a,
                                input logic [csi_pkg::IDX_W-1:0] idx);
      hit = (a[csi_pkg::ADR_W-1:2] == idx) && (a[1:0] == 2'h0);
   endfunction : hit

   // LSB-first enters at bit 7 so the first bit ends up at bit 0
   function automatic logic [7:0] shift_in(input logic [7:0] v, input logic b,
                                           input logic msb_first);
      shift_in = msb_first ? {v[6:0], b} : {b, v[7:1]};
   endfunction : shift_in

   function automatic logic out_bit(input logic [7:0] v, input logic msb_first);
      out_bit = msb_first ? v[7] : v[0];
   endfunction : out_bit

   // ----------------------------------------------------------------
   // Bus decode
   // ----------------------------------------------------------------
   logic req;
   logic wr;
   logic rd;
   logic data_access;

   assign req = cyc_i & stb_i & ~ack_o;
   // Reads ignore sel_i: every register answers in the low nibble;
   // writes need lane 0, which carries that nibble
   assign wr = req & we_i & sel_i[0];
   assign rd = req & ~we_i;
   assign data_access = (wr | rd) &
      (hit(adr_i, csi_pkg::IDX_DATA_LO) | hit(adr_i, csi_pkg::IDX_DATA_HI));

   // Ack for one cycle; the master drops its request after seeing it
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_o <= 1'b0;
      end else begin
         ack_o <= req;
      end
   end

   // ----------------------------------------------------------------
   // Control registers
   // ----------------------------------------------------------------
   // Pull-up bits D1 and D3 are not stored and read back as zero
   logic in_pullup_r;
   logic clk_pullup_r;
   logic fn_en_r;
   logic out_en_r;
   logic irq_en_r;
   logic pending_r;
   csi_pkg::clock_cfg_s cfg_r;
   csi_pkg::xfer_e state_r;
   logic done_ev;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         in_pullup_r <= csi_pkg::PU_RST;
         clk_pullup_r <= csi_pkg::PU_RST;
      end else if (wr && hit(adr_i, csi_pkg::IDX_PULLUPS)) begin
         in_pullup_r <= dat_i[csi_pkg::PU_IN_BIT];
         clk_pullup_r <= dat_i[csi_pkg::PU_CLK_BIT];
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         fn_en_r <= csi_pkg::CTRL_RST;
         out_en_r <= csi_pkg::CTRL_RST;
      end else if (wr && hit(adr_i, csi_pkg::IDX_ENABLE)) begin
         fn_en_r <= dat_i[csi_pkg::EN_FN_BIT];
         out_en_r <= dat_i[csi_pkg::EN_OUT_BIT];
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cfg_r <= csi_pkg::CFG_RST;
      // Mode changes mid-transfer are not guarded; software keeps them still
      end else if (wr && hit(adr_i, csi_pkg::IDX_CLK_CFG)) begin
         cfg_r <= csi_pkg::clock_cfg_s'(dat_i[3:0]);
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         irq_en_r <= csi_pkg::CTRL_RST;
      end else if (wr && hit(adr_i, csi_pkg::IDX_IRQ_MASK)) begin
         irq_en_r <= dat_i[csi_pkg::IRQ_BIT];
      end
   end

   // A completion in the clearing cycle wins over the clear
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pending_r <= csi_pkg::CTRL_RST;
      end else if (done_ev) begin
         pending_r <= 1'b1;
      end else if (wr && hit(adr_i, csi_pkg::IDX_IRQ_FLAG) &&
                   dat_i[csi_pkg::IRQ_BIT]) begin
         pending_r <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // Pin synchronisers
   // ----------------------------------------------------------------
   // Both pins reset to their idle level so no false edge follows reset
   logic sin_s1;
   logic sin_s2;
   logic sclk_s1;
   logic sclk_s2;
   logic sclk_s3;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         sin_s1 <= 1'b1;
         sin_s2 <= 1'b1;
         sclk_s1 <= csi_pkg::SCLK_IDLE;
         sclk_s2 <= csi_pkg::SCLK_IDLE;
         sclk_s3 <= csi_pkg::SCLK_IDLE;
      end else begin
         sin_s1 <= serial_in_pin_i;
         sin_s2 <= sin_s1;
         sclk_s1 <= sclk_pin_i;
         sclk_s2 <= sclk_s1;
         sclk_s3 <= sclk_s2;
      end
   end

   // ----------------------------------------------------------------
   // Shift clock source
   // ----------------------------------------------------------------
   logic master;
   logic running;
   logic half_div_r;
   logic tick;
   logic fall_ev;
   logic rise_ev;
   logic cap_ev;

   assign master = cfg_r.clock_mode != csi_pkg::CLK_SLAVE_EXT;
   // Divider runs free, so the first half-rate half period of a
   // transfer may be one oscillator edge short
   assign running = state_r == csi_pkg::XFER_RUN;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         half_div_r <= 1'b0;
      end else if (osc_edge_i) begin
         half_div_r <= ~half_div_r;
      end
   end

   // Each tick is one half period of the shift clock
   always_comb begin
      case (cfg_r.clock_mode)
         csi_pkg::CLK_MASTER_OSC: tick = osc_edge_i;
         csi_pkg::CLK_MASTER_HALF: tick = osc_edge_i & half_div_r;
         csi_pkg::CLK_MASTER_TIMER: tick = timer1_underflow_i;
         default: tick = 1'b0;
      endcase
   end

   // Slave edges come from the second and third sync stages only
   assign fall_ev = running & (master ? (tick & sclk_pin_o) : (sclk_s3 & ~sclk_s2));
   assign rise_ev = running & (master ? (tick & ~sclk_pin_o) : (~sclk_s3 & sclk_s2));
   assign cap_ev = cfg_r.sample_edge_sel ? fall_ev : rise_ev;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         sclk_pin_o <= csi_pkg::SCLK_IDLE;
      // Idle high, so the first tick of a transfer is a falling edge
      end else if (!running || !master) begin
         sclk_pin_o <= csi_pkg::SCLK_IDLE;
      end else if (tick) begin
         sclk_pin_o <= ~sclk_pin_o;
      end
   end

   // ----------------------------------------------------------------
   // Transfer sequencing
   // ----------------------------------------------------------------
   logic [2:0] cnt_r;
   logic trigger;

   assign trigger = wr && hit(adr_i, csi_pkg::IDX_ENABLE) && dat_i[csi_pkg::EN_TRG_BIT];
   // Counter counts rises; the eighth rise ends the transfer
   assign done_ev = rise_ev && (cnt_r == csi_pkg::LAST_BIT);

   // Repeated triggers while running are ignored rather than restarting
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state_r <= csi_pkg::XFER_IDLE;
      end else begin
         case (state_r)
            csi_pkg::XFER_IDLE: if (trigger) state_r <= csi_pkg::XFER_RUN;
            csi_pkg::XFER_RUN: if (done_ev) state_r <= csi_pkg::XFER_IDLE;
            default: state_r <= csi_pkg::XFER_IDLE;
         endcase
      end
   end

   // A data register access re-arms the bit counter
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cnt_r <= 3'h0;
      end else if (data_access || (trigger && !running)) begin
         cnt_r <= 3'h0;
      end else if (rise_ev) begin
         cnt_r <= cnt_r + 3'h1;
      end
   end

   // ----------------------------------------------------------------
   // Shift register, doubling as the data registers
   // ----------------------------------------------------------------
   logic [7:0] sr;
   // Writes and captures share this register, so a data write mid-transfer
   // corrupts the frame; software waits for the status to clear

   // No reset on purpose: contents are undefined after reset
   always_ff @(posedge clk_i) begin
      if (wr && hit(adr_i, csi_pkg::IDX_DATA_LO)) begin
         sr[3:0] <= dat_i[3:0];
      end else if (wr && hit(adr_i, csi_pkg::IDX_DATA_HI)) begin
         sr[7:4] <= dat_i[3:0];
      end else if (cap_ev) begin
         sr <= shift_in(sr, sin_s2, cfg_r.bit_order_sel);
      end
   end

   // Output bit taken before any same-edge capture shifts it away
   // In falling-sample mode one edge both presents and captures
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         serial_out_pin_o <= 1'b0;
      end else if (fall_ev) begin
         serial_out_pin_o <= out_bit(sr, cfg_r.bit_order_sel);
      end
   end

   // ----------------------------------------------------------------
   // Registered pin controls
   // ----------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         sclk_pin_oe_n_o <= 1'b1;
         serial_out_pin_oe_n_o <= 1'b1;
         slave_ready_pin_n_o <= 1'b1;
         slave_ready_pin_oe_n_o <= 1'b1;
         serial_pin_function_o <= 1'b0;
         input_pin_pullup_o <= csi_pkg::PU_RST;
         clock_pin_pullup_o <= csi_pkg::PU_RST;
         irq_o <= 1'b0;
      end else begin
         sclk_pin_oe_n_o <= ~(fn_en_r & master);
         serial_out_pin_oe_n_o <= ~(fn_en_r & out_en_r);
         // Ready is low while running and high again once the frame ends
         slave_ready_pin_n_o <= ~running;
         slave_ready_pin_oe_n_o <= ~(fn_en_r & ~master);
         serial_pin_function_o <= fn_en_r;
         input_pin_pullup_o <= in_pullup_r;
         clock_pin_pullup_o <= clk_pullup_r & ~(fn_en_r & master);
         irq_o <= pending_r & irq_en_r;
      end
   end

   // ----------------------------------------------------------------
   // Read data
   // ----------------------------------------------------------------
   // Unmapped addresses read as zero
   logic [3:0] rd_nib;

   always_comb begin
      rd_nib = 4'h0;
      if (hit(adr_i, csi_pkg::IDX_PULLUPS)) begin
         rd_nib[csi_pkg::PU_IN_BIT] = in_pullup_r;
         rd_nib[csi_pkg::PU_CLK_BIT] = clk_pullup_r;
      end else if (hit(adr_i, csi_pkg::IDX_ENABLE)) begin
         rd_nib[csi_pkg::EN_FN_BIT] = fn_en_r;
         rd_nib[csi_pkg::EN_TRG_BIT] = running;
         rd_nib[csi_pkg::EN_OUT_BIT] = out_en_r;
      end else if (hit(adr_i, csi_pkg::IDX_CLK_CFG)) begin
         rd_nib = cfg_r;
      end else if (hit(adr_i, csi_pkg::IDX_DATA_LO)) begin
         rd_nib = sr[3:0];
      end else if (hit(adr_i, csi_pkg::IDX_DATA_HI)) begin
         rd_nib = sr[7:4];
      end else if (hit(adr_i, csi_pkg::IDX_IRQ_MASK)) begin
         rd_nib[csi_pkg::IRQ_BIT] = irq_en_r;
      end else if (hit(adr_i, csi_pkg::IDX_IRQ_FLAG)) begin
         rd_nib[csi_pkg::IRQ_BIT] = pending_r;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         dat_o <= '0;
      // Registered so the read data stands together with ack
      end else if (rd) begin
         dat_o <= {28'h0, rd_nib};
      end
   end

endmodule : clocked_serial_interface

`default_nettype wire

//--- csi_pkg.sv
package csi_pkg;

   // ----------------------------------------------------------------
   // Bus geometry
   // ----------------------------------------------------------------
   localparam int ADR_W = 18;
   localparam int IDX_W = 16;
   localparam int DAT_W = 32;

   // Register indices; byte address is four times the index
   localparam logic [IDX_W-1:0] IDX_PULLUPS = 16'hff45;
   localparam logic [IDX_W-1:0] IDX_ENABLE = 16'hff70;
   localparam logic [IDX_W-1:0] IDX_CLK_CFG = 16'hff71;
   localparam logic [IDX_W-1:0] IDX_DATA_LO = 16'hff72;
   localparam logic [IDX_W-1:0] IDX_DATA_HI = 16'hff73;
   localparam logic [IDX_W-1:0] IDX_IRQ_MASK = 16'hffe3;
   localparam logic [IDX_W-1:0] IDX_IRQ_FLAG = 16'hfff3;

   // ----------------------------------------------------------------
   // Field positions
   // ----------------------------------------------------------------
   localparam int PU_IN_BIT = 0;
   localparam int PU_CLK_BIT = 2;
   localparam int EN_FN_BIT = 0;
   localparam int EN_TRG_BIT = 1;
   localparam int EN_OUT_BIT = 2;
   localparam int IRQ_BIT = 0;

   // ----------------------------------------------------------------
   // Reset values and counts
   // ----------------------------------------------------------------
   localparam logic PU_RST = 1'b1;
   localparam logic CTRL_RST = 1'b0;
   localparam logic SCLK_IDLE = 1'b1;
   localparam int XFER_BITS = 8;
   localparam logic [2:0] LAST_BIT = 3'h7;

   // ----------------------------------------------------------------
   // Types
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      CLK_SLAVE_EXT = 2'b00,
      CLK_MASTER_TIMER = 2'b01,
      CLK_MASTER_HALF = 2'b10,
      CLK_MASTER_OSC = 2'b11
   } clk_mode_e;

   typedef enum logic {
      XFER_IDLE = 1'b0,
      XFER_RUN = 1'b1
   } xfer_e;

   // Nibble layout of the clock configuration register, D3..D0
   typedef struct packed {
      logic bit_order_sel;
      logic sample_edge_sel;
      clk_mode_e clock_mode;
   } clock_cfg_s;

   localparam clock_cfg_s CFG_RST = '{1'b0, 1'b0, CLK_SLAVE_EXT};

endpackage : csi_pkg

//--- csi_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module csi_monitor (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [csi_pkg::ADR_W-1:0] adr_i,
   input wire logic [csi_pkg::DAT_W-1:0] dat_i,
   input wire logic ack_o,
   input wire logic sclk_pin_o,
   input wire logic sclk_pin_oe_n_o,
   input wire logic serial_out_pin_o,
   input wire logic serial_out_pin_oe_n_o,
   input wire logic slave_ready_pin_n_o,
   input wire logic slave_ready_pin_oe_n_o,
   input wire logic serial_pin_function_o,
   input wire logic input_pin_pullup_o,
   input wire logic clock_pin_pullup_o,
   input wire logic irq_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   // ----------------------------------------------------------------
   // Driven shift clock rises since the last trigger write
   // ----------------------------------------------------------------
   logic [3:0] rise_cnt_r;
   logic trg_wr;
   assign trg_wr = ack_o && we_i && adr_i[17:2] == csi_pkg::IDX_ENABLE
      && dat_i[csi_pkg::EN_TRG_BIT];
   always_ff @(posedge clk_i) begin
      if (rst_i || trg_wr) begin
         rise_cnt_r <= 4'h0;
      end else if (!sclk_pin_oe_n_o && $rose(sclk_pin_o)) begin
         rise_cnt_r <= rise_cnt_r + 4'h1;
      end
   end
   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   a_ack_one_cycle: assert property (ack_o |=> !ack_o)
      else $error("ack held for more than one cycle");
   a_ack_prompt: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
      else $error("request not answered in one cycle");
   a_reset_state: assert property ($fell(rst_i) |-> input_pin_pullup_o && clock_pin_pullup_o
      && sclk_pin_oe_n_o && serial_out_pin_oe_n_o && !irq_o)
      else $error("wrong pin state after reset");
   a_clk_pullup_master: assert property (!sclk_pin_oe_n_o && $past(!sclk_pin_oe_n_o)
      |-> !clock_pin_pullup_o) else $error("clock pull-up active in master mode");
   a_out_on_fall: assert property (!sclk_pin_oe_n_o && $changed(serial_out_pin_o)
      |-> $fell(sclk_pin_o)) else $error("serial out changed off the falling edge");
   a_out_drive_fn: assert property (!serial_out_pin_oe_n_o && $past(!serial_out_pin_oe_n_o)
      |-> serial_pin_function_o) else $error("serial out driven with pins not assigned");
   a_pin_roles: assert property (!(!slave_ready_pin_oe_n_o && !sclk_pin_oe_n_o))
      else $error("ready pin and clock pin driven together");
   a_eight_clocks: assert property (rise_cnt_r <= 4'h8)
      else $error("more than eight shift clocks per trigger");
   a_flag_on_eighth: assert property ($rose(irq_o) && !sclk_pin_oe_n_o |-> rise_cnt_r == 4'h8)
      else $error("interrupt raised before eighth shift clock");
   c_irq: cover property ($rose(irq_o));
   c_master_clk: cover property (!sclk_pin_oe_n_o && $rose(sclk_pin_o));
   c_slave_run: cover property (!slave_ready_pin_oe_n_o && $fell(slave_ready_pin_n_o));
endmodule : csi_monitor

bind clocked_serial_interface csi_monitor u_mon (.*);
`default_nettype wire

//--- serial_partner.sv
`timescale 1ns/1ps
`default_nettype none
module serial_partner (
   input wire logic clk_i,
   input wire logic act_i,
   input wire logic gen_i,
   input wire logic msb_i,
   input wire logic fall_i,
   input wire logic [7:0] tx_i,
   input wire logic sclk_i,
   input wire logic serial_out_pin_i,
   output logic sclk_o,
   output logic sin_o,
   output logic [7:0] rx_o
);
   logic prev_r;
   logic tgl_r = 1'b0;
   logic [2:0] falls_r, rises_r, pos;
   logic [6:0] ph_r;
   logic [4:0] half_r;
   // Half period of 125 cycles keeps the clock at 1 MHz; idle high
   always_ff @(posedge clk_i) begin
      if (!act_i || !gen_i) begin
         sclk_o <= 1'b1;
         ph_r <= 7'h0;
         half_r <= 5'h0;
      end else if (half_r != 5'h10) begin
         ph_r <= (ph_r == 7'h7c) ? 7'h0 : ph_r + 7'h1;
         if (ph_r == 7'h7c) begin
            sclk_o <= ~sclk_o;
            half_r <= half_r + 5'h1;
         end
      end
   end
   always_ff @(posedge clk_i) begin
      prev_r <= sclk_i;
      tgl_r <= ~tgl_r;
      if (!act_i) begin
         falls_r <= 3'h0;
         rises_r <= 3'h0;
      end else begin
         if (prev_r && !sclk_i) falls_r <= falls_r + 3'h1;
         if (!prev_r && sclk_i) begin
            rises_r <= rises_r + 3'h1;
            rx_o <= msb_i ? {rx_o[6:0], serial_out_pin_i} : {serial_out_pin_i, rx_o[7:1]};
         end
      end
   end
   // Falling sampling: hold each bit across the falling edge
   assign pos = fall_i ? rises_r : falls_r - 3'h1;
   // Released line toggles so no stale level can pass for data
   assign sin_o = !act_i ? tgl_r : tx_i[msb_i ? 3'h7 - pos : pos];
endmodule : serial_partner
`default_nettype wire

//--- clocked_serial_interface_test.sv
`timescale 1ns/1ps
`default_nettype none
module clocked_serial_interface_test;
   logic clk_i = 1'b0, rst_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
   logic [17:0] adr_i = 18'h0;
   logic [3:0] sel_i = 4'h0;
   logic [31:0] dat_i = 32'h0, dat_o;
   logic osc_edge_i = 1'b0, timer1_underflow_i = 1'b0, act = 1'b0, gen = 1'b0, msb = 1'b0;
   logic fall = 1'b0, ack_o, sclk_pin_i, serial_in_pin_i, sclk_pin_o, sclk_pin_oe_n_o;
   logic serial_out_pin_o, serial_out_pin_oe_n_o, slave_ready_pin_n_o, slave_ready_pin_oe_n_o;
   logic irq_o, serial_pin_function_o, input_pin_pullup_o, clock_pin_pullup_o, p_sclk;
   logic [7:0] tick = 8'h0, ptx = 8'h0, prx;
   logic [31:0] exp_q[$];
   int err_count = 0, n_checks = 0;
   always #2 clk_i = ~clk_i;
   // Timer underflow every 128 cycles keeps its shift clock under 1 MHz
   always @(posedge clk_i) begin
      tick <= tick + 8'h1;
      osc_edge_i <= tick[2:0] == 3'h7;
      timer1_underflow_i <= tick[6:0] == 7'h7f;
   end
   // Clock pin has a pull-up when nobody drives it
   assign sclk_pin_i = sclk_pin_oe_n_o === 1'b0 ? sclk_pin_o : (p_sclk !== 1'b0);
   clocked_serial_interface DUT (.*);
   serial_partner u_far (.clk_i(clk_i), .act_i(act), .gen_i(gen), .msb_i(msb), .fall_i(fall),
      .tx_i(ptx), .sclk_i(sclk_pin_i), .serial_out_pin_i(serial_out_pin_oe_n_o ? tick[0] : serial_out_pin_o),
      .sclk_o(p_sclk), .sin_o(serial_in_pin_i), .rx_o(prx));
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         err_count++;
         $display("ERROR %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk
   task automatic wb(input logic w, input logic [15:0] idx, input logic [3:0] d, input logic [3:0] e);
      @(posedge clk_i);
      cyc_i <= 1'b1;
      stb_i <= 1'b1;
      we_i <= w;
      adr_i <= {idx, 2'b00};
      sel_i <= 4'hf;
      dat_i <= {28'($urandom()), d};
      if (!w) exp_q.push_back({28'h0, e});
      do begin
         @(posedge clk_i);
      end while (ack_o !== 1'b1);
      cyc_i <= 1'b0;
      stb_i <= 1'b0;
      we_i <= 1'b0;
   endtask : wb
   always @(posedge clk_i) begin
      if (ack_o === 1'b1 && we_i === 1'b0) chk("read data", dat_o, exp_q.pop_front());
   end
   task automatic complete_run;
      if (exp_q.size() != 0) err_count++;
      $display("checks %0d mismatches %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : complete_run
   // Five transfers' worth of bus work plus settle waits fit well inside this
   initial begin
      #300000;
      err_count++;
      complete_run();
   end
   initial begin
      logic [7:0] dtx, rtx;
      logic m_v, f_v;
      int n;
      void'($urandom(32'hd450));
      repeat (10) @(posedge clk_i);
      rst_i <= 1'b0;
      repeat (2) @(posedge clk_i);
      chk("reset pins", 32'({input_pin_pullup_o, clock_pin_pullup_o, irq_o}), 32'h6);
      wb(1'b0, csi_pkg::IDX_PULLUPS, 4'h0, 4'h5);
      wb(1'b0, csi_pkg::IDX_ENABLE, 4'h0, 4'h0);
      wb(1'b0, csi_pkg::IDX_CLK_CFG, 4'h0, 4'h0);
      wb(1'b0, csi_pkg::IDX_IRQ_MASK, 4'h0, 4'h0);
      wb(1'b0, csi_pkg::IDX_IRQ_FLAG, 4'h0, 4'h0);
      wb(1'b1, 16'h0100, 4'hf, 4'h0);
      wb(1'b0, 16'h0100, 4'h0, 4'h0);
      $display("reset values test done");
      wb(1'b1, csi_pkg::IDX_PULLUPS, 4'h0, 4'h0);
      repeat (2) @(posedge clk_i);
      chk("pull-up pins off", 32'({input_pin_pullup_o, clock_pin_pullup_o}), 32'h0);
      wb(1'b0, csi_pkg::IDX_PULLUPS, 4'h0, 4'h0);
      wb(1'b1, csi_pkg::IDX_PULLUPS, 4'h5, 4'h0);
      wb(1'b1, csi_pkg::IDX_IRQ_MASK, 4'h1, 4'h0);
      $display("pull-up test done");
      for (int i = 0; i < 5; i++) begin
         m_v = 1'($urandom());
         f_v = 1'($urandom());
         dtx = 8'($urandom());
         rtx = 8'($urandom());
         msb <= m_v;
         fall <= f_v;
         ptx <= rtx;
         gen <= i[1:0] == 2'b00;
         // Order first, then data, then a data access before the trigger
         wb(1'b1, csi_pkg::IDX_CLK_CFG, {m_v, f_v, i[1:0]}, 4'h0);
         wb(1'b0, csi_pkg::IDX_CLK_CFG, 4'h0, {m_v, f_v, i[1:0]});
         wb(1'b1, csi_pkg::IDX_DATA_LO, dtx[3:0], 4'h0);
         wb(1'b1, csi_pkg::IDX_DATA_HI, dtx[7:4], 4'h0);
         wb(1'b0, csi_pkg::IDX_DATA_HI, 4'h0, dtx[7:4]);
         wb(1'b1, csi_pkg::IDX_ENABLE, 4'h5, 4'h0);
         repeat (2500) @(posedge clk_i);
         act <= 1'b1;
         wb(1'b1, csi_pkg::IDX_ENABLE, 4'h7, 4'h0);
         wb(1'b0, csi_pkg::IDX_ENABLE, 4'h0, 4'h7);
         chk("pin roles", 32'({sclk_pin_oe_n_o, slave_ready_pin_oe_n_o, slave_ready_pin_n_o,
            serial_pin_function_o}), (i[1:0] == 2'b00) ? 32'h9 : 32'h5);
         n = 0;
         while (irq_o !== 1'b1 && n < 5000) begin
            @(posedge clk_i);
            n++;
         end
         if (n >= 5000) err_count++;
         act <= 1'b0;
         wb(1'b0, csi_pkg::IDX_ENABLE, 4'h0, 4'h5);
         wb(1'b0, csi_pkg::IDX_IRQ_FLAG, 4'h0, 4'h1);
         wb(1'b0, csi_pkg::IDX_DATA_LO, 4'h0, rtx[3:0]);
         wb(1'b0, csi_pkg::IDX_DATA_HI, 4'h0, rtx[7:4]);
         chk("far end byte", 32'(prx), 32'(dtx));
         wb(1'b1, csi_pkg::IDX_IRQ_MASK, 4'h0, 4'h0);
         repeat (2) @(posedge clk_i);
         chk("irq masked", 32'(irq_o), 32'h0);
         wb(1'b1, csi_pkg::IDX_IRQ_MASK, 4'h1, 4'h0);
         repeat (2) @(posedge clk_i);
         chk("irq unmasked", 32'(irq_o), 32'h1);
         wb(1'b1, csi_pkg::IDX_IRQ_FLAG, 4'h0, 4'h0);
         wb(1'b0, csi_pkg::IDX_IRQ_FLAG, 4'h0, 4'h1);
         wb(1'b1, csi_pkg::IDX_IRQ_FLAG, 4'h1, 4'h0);
         repeat (2) @(posedge clk_i);
         chk("irq cleared", 32'(irq_o), 32'h0);
         wb(1'b1, csi_pkg::IDX_ENABLE, 4'h0, 4'h0);
         $display("transfer test %0d done", i);
      end
      complete_run();
   end
endmodule : clocked_serial_interface_test
`default_nettype wire
